/* File: ddr2_burst2_sram_port.v */
// burst-of-two double-data-rate sram port: command decode, pll lock, read and write pipes
`timescale 1ns/10ps
`include "ddr2_port_regs.vh"

// What this block does
// - with pll enabled, lock is declared after 20 us of running input clock
// - input clock stopped at least 30 ns drops lock; relock follows restart
// - pll_disable_n low turns pll off and gives one-cycle read latency
// - write at t with load_n and read_not_write low; data at t+1 both edges
// - read at t gives first word at t+1, second word at t+1.5 with pll off; each half a cycle later with pll on
// - after reset outputs are tristated until a read is served
// - stopped clock holds all state and outputs unchanged except pll lock tracking (stop count, lock count, pll_locked)
// - 18 and 36 bit: second word uses address with lsb inverted
// - 8 and 9 bit: burst uses internal bit zero then one
// - write data taken on both input edges, read data on output edges
// - 18 bit: select bit 0 writes [8:0], bit 1 writes [17:9]
// - 8 bit: nibble select 0 writes [3:0], select 1 writes [7:4]
// - all selects high writes nothing for that half burst
// - 9 bit: one select governs bits [8:0] each data edge
// - selects sampled and applied independently on each data edge
// - deselect after read finishes read, then tristates after next output edge
// - read of address written previous cycle returns newest data
module ddr2_burst2_sram_port #(
  parameter WIDTH = 18,
  parameter ADDR_W = 8,
  parameter NSEL = (WIDTH == 36) ? 4 : ((WIDTH == 9) ? 1 : 2)
) (
  input wire core_clk,
  input wire rst,
  input wire k_running,
  input wire pll_disable_n,
  input wire load_n,
  input wire read_not_write,
  input wire [ADDR_W-1:0] addr,
  input wire [WIDTH-1:0] d_in,
  input wire [NSEL-1:0] byte_write_select_n,
  input wire [1:0] nibble_write_select_n,
  output reg [WIDTH-1:0] q_out,
  output reg q_oe_n,
  output reg pll_locked,
  output reg k_phase
);

  localparam IDX_W = ADDR_W + 1;
  localparam LANE = (WIDTH == 8) ? 4 : 9;
  localparam SHORT = (WIDTH == 8) || (WIDTH == 9);

  // ==========================================================
  // burst index: long variants flip lsb, short ones append burst bit
  function [IDX_W-1:0] burst_idx;
    input [ADDR_W-1:0] a;
    input b;
    begin
      if (SHORT)
        burst_idx = {a, b};
      else
        burst_idx = {1'b0, a[ADDR_W-1:1], a[0] ^ b};
    end
  endfunction

  // per-bit write mask from the lane selects of one data edge
  function [WIDTH-1:0] lane_mask;
    input [NSEL-1:0] bsel_n;
    input [1:0] nsel_n;
    integer i;
    begin
      lane_mask = {WIDTH{1'b0}};
      for (i = 0; i < WIDTH; i = i + 1) begin
        if (WIDTH == 8)
          lane_mask[i] = ~nsel_n[i / LANE];
        else
          lane_mask[i] = ~bsel_n[i / LANE];
      end
    end
  endfunction

  // ==========================================================
  // pll lock tracking
  reg [9:0] lock_cnt_q;
  reg [3:0] stop_cnt_q;
  wire run = k_running & ~rst;

  // ==========================================================
  // last count of lock and stop, cut to counter width on purpose
  localparam [31:0] LOCK_LAST_W = `PLL_LOCK_CYC - 1;
  localparam [31:0] STOP_LAST_W = `PLL_STOP_CYC - 1;
  wire [9:0] lock_last = LOCK_LAST_W[9:0];
  wire [3:0] stop_last = STOP_LAST_W[3:0];

  always @(posedge core_clk) begin
    if (rst) begin
      lock_cnt_q <= 10'h000;
      stop_cnt_q <= 4'h0;
      pll_locked <= `RST_LOCKED;
    end else if (!pll_disable_n) begin
      lock_cnt_q <= 10'h000;
      stop_cnt_q <= 4'h0;
      pll_locked <= 1'b0;
    end else if (!k_running) begin
      if (stop_cnt_q != 4'hf)
        stop_cnt_q <= stop_cnt_q + 4'h1;
      if (stop_cnt_q >= stop_last) begin
        lock_cnt_q <= 10'h000;
        pll_locked <= 1'b0;
      end
    end else begin
      stop_cnt_q <= 4'h0;
      if (lock_cnt_q >= lock_last)
        pll_locked <= 1'b1;
      else
        lock_cnt_q <= lock_cnt_q + 10'h001;
    end
  end

  // ==========================================================
  // command decode on positive input edge (phase 0)
  wire cmd_edge = run & ~k_phase;
  wire rd_ok = ~pll_disable_n | pll_locked;
  wire rd_cmd = cmd_edge & ~load_n & read_not_write & rd_ok;
  wire wr_cmd = cmd_edge & ~load_n & ~read_not_write;

  always @(posedge core_clk) begin
    if (rst)
      k_phase <= `RST_PHASE;
    else if (run)
      k_phase <= ~k_phase;
  end

  // ==========================================================
  // half-cycle pipes for read and write
  reg [3:0] rv_q;
  reg [ADDR_W-1:0] ra_q [0:3];
  reg [2:0] wv_q;
  reg [ADDR_W-1:0] wa_q [0:2];
  integer s;

  always @(posedge core_clk) begin
    if (rst) begin
      rv_q <= 4'h0;
      wv_q <= 3'h0;
      for (s = 0; s < 4; s = s + 1)
        ra_q[s] <= {ADDR_W{1'b0}};
      for (s = 0; s < 3; s = s + 1)
        wa_q[s] <= {ADDR_W{1'b0}};
    end else if (run) begin
      rv_q <= {rv_q[2:0], rd_cmd};
      wv_q <= {wv_q[1:0], wr_cmd};
      ra_q[0] <= addr;
      wa_q[0] <= addr;
      for (s = 1; s < 4; s = s + 1)
        ra_q[s] <= ra_q[s-1];
      for (s = 1; s < 3; s = s + 1)
        wa_q[s] <= wa_q[s-1];
    end
  end

  // ==========================================================
  // write beats: k rise then k# rise of cycle t+1
  wire wr_b0 = run & wv_q[1];
  wire wr_b1 = run & wv_q[2];
  reg [IDX_W-1:0] w_idx;
  reg [WIDTH-1:0] w_mask;

  always @* begin
    w_idx = burst_idx(wa_q[1], 1'b0);
    if (wr_b1)
      w_idx = burst_idx(wa_q[2], 1'b1);
    w_mask = lane_mask(byte_write_select_n, nibble_write_select_n);
  end

  // ==========================================================
  // read words: stage picked by pll mode
  // pll_disable_n is a strap: changing it with a read in flight moves the word stage
  wire pll_on = pll_disable_n;
  wire rd_w0 = pll_on ? rv_q[`RD_STAGE_PLL] : rv_q[`RD_STAGE_NOPLL];
  wire rd_w1 = pll_on ? rv_q[`RD_STAGE_PLL+1] : rv_q[`RD_STAGE_NOPLL+1];
  reg [IDX_W-1:0] r_idx;
  wire [WIDTH-1:0] r_data;
  // address of each word, taken from the stage that matches the mode
  wire [ADDR_W-1:0] rd_a0 = pll_on ? ra_q[`RD_STAGE_PLL] : ra_q[`RD_STAGE_NOPLL];
  wire [ADDR_W-1:0] rd_a1 = pll_on ? ra_q[`RD_STAGE_PLL+1] : ra_q[`RD_STAGE_NOPLL+1];

  always @* begin
    if (rd_w0)
      r_idx = burst_idx(rd_a0, 1'b0);
    else
      r_idx = burst_idx(rd_a1, 1'b1);
  end

  // array is written at each data edge, so a following read sees newest data
  ddr2_burst_array #(
    .WIDTH(WIDTH),
    .IDX_W(IDX_W)
  ) u_array (
    .core_clk(core_clk),
    .we(wr_b0 | wr_b1),
    .w_idx(w_idx),
    .w_data(d_in),
    .w_mask(w_mask),
    .r_idx(r_idx),
    .r_data(r_data)
  );

  // ==========================================================
  // output register and enable
  always @(posedge core_clk) begin
    if (rst) begin
      q_out <= {WIDTH{1'b0}};
      q_oe_n <= `RST_OE_N;
    end else if (run) begin
      if (rd_w0 | rd_w1) begin
        q_out <= r_data;
        q_oe_n <= 1'b0;
      end else begin
        q_oe_n <= 1'b1;
      end
    end
  end

endmodule // ddr2_burst2_sram_port

/* File: ddr2_port_regs.vh */
// timing counts, pipeline stages and reset values of the burst-of-two sram port
`ifndef DDR2_PORT_REGS_VH
`define DDR2_PORT_REGS_VH

// ==========================================================
// clock and timing
`define CORE_CLK_MHZ 25
`define CORE_CLK_NS 40
`define PLL_LOCK_US 20
`define PLL_LOCK_CYC (`PLL_LOCK_US * `CORE_CLK_MHZ)
`define PLL_STOP_NS 30
`define PLL_STOP_CYC ((`PLL_STOP_NS + `CORE_CLK_NS - 1) / `CORE_CLK_NS)

// ==========================================================
// read pipeline stage that loads the first word
`define RD_STAGE_PLL 2
`define RD_STAGE_NOPLL 1

// ==========================================================
// reset values
`define RST_PHASE 1'b0
`define RST_LOCKED 1'b0
`define RST_OE_N 1'b1

`endif

/* File: ddr2_burst_array.v */
// flip-flop storage array with per-bit write mask and one combinational read port
`timescale 1ns/10ps

module ddr2_burst_array #(
  parameter WIDTH = 18,
  parameter IDX_W = 9
) (
  input wire core_clk,
  input wire we,
  input wire [IDX_W-1:0] w_idx,
  input wire [WIDTH-1:0] w_data,
  input wire [WIDTH-1:0] w_mask,
  input wire [IDX_W-1:0] r_idx,
  output wire [WIDTH-1:0] r_data
);

  reg [WIDTH-1:0] mem_q [0:(1<<IDX_W)-1];

  // ==========================================================
  // write: masked bits keep their stored value
  always @(posedge core_clk) begin
    if (we) begin
      mem_q[w_idx] <= (mem_q[w_idx] & ~w_mask) | (w_data & w_mask);
    end
  end

  assign r_data = mem_q[r_idx];

endmodule // ddr2_burst_array

/* File: port_props.sv */
// checker for the burst sram port
`timescale 1ns/10ps
module port_props #(parameter WIDTH = 18) (
  input logic core_clk,
  input logic rst,
  input logic k_running,
  input logic pll_disable_n,
  input logic load_n,
  input logic read_not_write,
  input logic [WIDTH-1:0] q_out,
  input logic q_oe_n,
  input logic pll_locked,
  input logic k_phase
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  logic [9:0] cnt_q;
  wire rd = k_running && !k_phase && !load_n && read_not_write;
  // running cycles with the pll on and not yet locked
  always @(posedge core_clk)
    if (rst || !k_running || pll_locked || !pll_disable_n) cnt_q <= 10'h0;
    else cnt_q <= cnt_q + 10'h1;
  property p_rst; disable iff (1'b0) rst |=> q_oe_n && !pll_locked && !k_phase; endproperty
  a_rst: assert property (p_rst) else $error("reset state wrong");
  property p_phase; k_running |=> k_phase != $past(k_phase); endproperty
  a_phase: assert property (p_phase) else $error("half cycle slot stuck");
  property p_hold; !k_running |=> $stable(q_out) && $stable(q_oe_n) && $stable(k_phase); endproperty
  a_hold: assert property (p_hold) else $error("state moved while stopped");
  property p_lat_off; rd && !pll_disable_n ##1 k_running [*2] |=> !q_oe_n; endproperty
  a_lat_off: assert property (p_lat_off) else $error("short latency read late");
  property p_lat_on; rd && pll_locked ##1 k_running [*3] |=> !q_oe_n; endproperty
  a_lat_on: assert property (p_lat_on) else $error("long latency read late");
  property p_lock; $rose(pll_locked) |-> cnt_q >= 10'd499 && cnt_q <= 10'd501; endproperty
  a_lock: assert property (p_lock) else $error("lock time wrong");
  property p_relock; pll_disable_n && !k_running ##1 k_running |=> !pll_locked; endproperty
  a_relock: assert property (p_relock) else $error("lock kept over stop");
  property p_release;
    !pll_disable_n && !q_oe_n && k_running && $past(k_running) && $past(k_running, 2)
      && $past(k_running, 3) && $past(load_n, 2) && $past(load_n, 3) |=> q_oe_n;
  endproperty
  a_release: assert property (p_release) else $error("output not released");
endmodule // port_props
bind ddr2_burst2_sram_port port_props #(.WIDTH(WIDTH)) chk (.*);

/* File: ctl_model.sv */
// controller model: commands on phase-0 slots, write data on both halves of the following cycle
`timescale 1ns/10ps
module ctl_model (
  input logic core_clk,
  input logic k_phase,
  output logic load_n = 1'b1,
  output logic read_not_write = 1'b0,
  output logic [7:0] addr = 8'h0,
  output logic [17:0] d_in = 18'h0,
  output logic [1:0] byte_write_select_n = 2'h3
);
  task automatic cmd(input logic rnw, input logic [7:0] a);
    @(negedge core_clk);
    while (k_phase !== 1'b0) @(negedge core_clk);
    load_n = 1'b0;
    read_not_write = rnw;
    addr = a;
    @(negedge core_clk);
    load_n = 1'b1;
    addr = ~a;
  endtask
  task automatic wr(input logic [7:0] a, input logic [17:0] d0, d1, input logic [1:0] s0, s1);
    cmd(1'b0, a);
    @(negedge core_clk);
    d_in = d0;
    byte_write_select_n = s0;
    @(negedge core_clk);
    d_in = d1;
    byte_write_select_n = s1;
    @(negedge core_clk);
    d_in = ~d1;
  endtask
endmodule // ctl_model

/* File: ddr2_burst2_sram_port_tb_top.sv */
// self-checking bench for the burst sram port
`timescale 1ns/10ps
module ddr2_burst2_sram_port_tb_top;
  logic core_clk, rst, k_running, pll_disable_n, load_n, read_not_write, q_oe_n, pll_locked;
  logic k_phase;
  logic [7:0] addr;
  logic [17:0] d_in, q_out;
  logic [1:0] bsel_n;
  int bad_count = 0;
  int checks = 0;
  int n;
  time t0;
  // one row: write inputs, then the two words a read of the same address gives
  typedef struct packed {logic [7:0] a; logic [17:0] d0, d1; logic [1:0] s0, s1;
    logic [17:0] e0, e1;} row_t;
  row_t rows [4];
  ddr2_burst2_sram_port uut (.core_clk(core_clk), .rst(rst), .k_running(k_running),
    .pll_disable_n(pll_disable_n), .load_n(load_n), .read_not_write(read_not_write),
    .addr(addr), .d_in(d_in), .byte_write_select_n(bsel_n), .nibble_write_select_n(2'h3),
    .q_out(q_out), .q_oe_n(q_oe_n), .pll_locked(pll_locked), .k_phase(k_phase));
  ctl_model m (.core_clk(core_clk), .k_phase(k_phase), .load_n(load_n),
    .read_not_write(read_not_write), .addr(addr), .d_in(d_in), .byte_write_select_n(bsel_n));
  task automatic chk(input string s, input logic [17:0] v, e);
    checks++;
    if (v !== e) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", s, e, v);
    end
  endtask
  task automatic rd(input logic [7:0] a, input int lat, input logic [17:0] e0, e1);
    m.cmd(1'b1, a);
    repeat (lat) @(negedge core_clk);
    chk("oe", q_oe_n, 1'b0);
    chk("w0", q_out, e0);
    @(negedge core_clk);
    chk("w1", q_out, e1);
    @(negedge core_clk);
    chk("off", q_oe_n, 1'b1);
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  initial begin
    #(40 * 3000);
    bad_count++;
    results;
  end
  initial begin
    rst = 1'b1;
    k_running = 1'b1;
    pll_disable_n = 1'b0;
    rows[0] = {8'h10, 18'h2a5c3, 18'h15a3c, 2'h0, 2'h0, 18'h2a5c3, 18'h15a3c};
    rows[1] = {8'h10, 18'h3ffff, 18'h00000, 2'h1, 2'h2, 18'h3ffc3, 18'h15a00};
    rows[2] = {8'h21, 18'h0f0f0, 18'h30303, 2'h0, 2'h0, 18'h0f0f0, 18'h30303};
    rows[3] = {8'h21, 18'h00000, 18'h00000, 2'h3, 2'h3, 18'h0f0f0, 18'h30303};
    repeat (6) @(negedge core_clk);
    rst = 1'b0;
    chk("rst oe", q_oe_n, 1'b1);
    for (int i = 0; i < 4; i++) begin
      m.wr(rows[i].a, rows[i].d0, rows[i].d1, rows[i].s0, rows[i].s1);
      rd(rows[i].a, 2, rows[i].e0, rows[i].e1);
    end
    k_running = 1'b0;
    repeat (3) @(negedge core_clk);
    k_running = 1'b1;
    rd(8'h10, 2, 18'h3ffc3, 18'h15a00);
    pll_disable_n = 1'b1;
    t0 = $time;
    m.cmd(1'b1, 8'h10);
    repeat (4) begin
      @(negedge core_clk);
      chk("early", q_oe_n, 1'b1);
    end
    while (pll_locked !== 1'b1 && $time - t0 < 40 * 700) @(negedge core_clk);
    n = int'(($time - t0) / 40);
    chk("lock", n > 497 && n < 504, 1'b1);
    rd(8'h21, 3, 18'h0f0f0, 18'h30303);
    k_running = 1'b0;
    repeat (2) @(negedge core_clk);
    k_running = 1'b1;
    repeat (2) @(negedge core_clk);
    chk("relock", pll_locked, 1'b0);
    results;
  end
endmodule // ddr2_burst2_sram_port_tb_top
